// ---- design/scale_discrete_io_port.sv ----
// Function
// - in displayed mode, analog output follows weight magnitude below zero
// - under-zero blanking forces analog under-range level and alarm
// - over capacity analog keeps rising; at blanking jumps over-range, alarm
// - three inputs and five outputs, each with its own function select
// - an input is asserted only while grounded
// - level functions active exactly while input is grounded
// - edge functions: tare, clear, zero, print, units, dynamic, total, advance
// - level functions: blank, inhibit keypad, tenfold, feed permit, discharge permit
// - advance prompt: first prompt from weighing mode, else next prompt
// - an undriven input reads inactive
// - output sources: setpoint, net, center zero, motion, over capacity, negative, none
// - setpoint outputs active low, on while weight below setpoint
// - setpoint compares weight magnitude
// - setpoint weight selectable gross, displayed or net
// - net setpoint stays off until a tare is taken
// - alarm only while display is at under-zero blanking or at over blanking, not merely over capacity
`timescale 1ns/10ps
`default_nettype none

module scale_discrete_io_port #(
    parameter int WEIGHT_WIDTH = scale_io_pkg::WEIGHT_WIDTH,
    parameter int HOLD_CYCLES  = scale_io_pkg::EDGE_HOLD_CYCLES
) (
    input  wire logic                    i_clock,
    input  wire logic                    i_reset,
    input  wire logic [2:0]              i_input_n,
    input  wire logic [11:0]             i_input_function,
    input  wire logic                    i_prompt_mode,
    output logic                         o_tare_pulse,
    output logic                         o_clear_pulse,
    output logic                         o_zero_pulse,
    output logic                         o_print_pulse,
    output logic                         o_switch_units_pulse,
    output logic                         o_dynamic_pulse,
    output logic                         o_accumulator_total_pulse,
    output logic                         o_prompt_first_pulse,
    output logic                         o_prompt_next_pulse,
    output logic                         o_blank_display,
    output logic                         o_inhibit_keypad,
    output logic                         o_tenfold_resolution_display,
    output logic                         o_feed_permit,
    output logic                         o_discharge_permit,
    input  wire logic [14:0]             i_output_source,
    input  wire logic [5*WEIGHT_WIDTH-1:0] i_setpoint_value,
    input  wire logic [1:0]              i_setpoint_weight_select,
    input  wire logic signed [WEIGHT_WIDTH-1:0] i_gross_weight,
    input  wire logic signed [WEIGHT_WIDTH-1:0] i_net_weight,
    input  wire logic signed [WEIGHT_WIDTH-1:0] i_displayed_weight,
    input  wire logic                    i_tare_taken,
    input  wire logic                    i_net_mode,
    input  wire logic                    i_center_of_zero,
    input  wire logic                    i_in_motion,
    input  wire logic [WEIGHT_WIDTH-1:0] i_full_scale_capacity,
    input  wire logic [WEIGHT_WIDTH-1:0] i_over_blanking_value,
    input  wire logic [WEIGHT_WIDTH-1:0] i_zero_blanking_value,
    input  wire logic                    i_analog_follows_displayed,
    output logic [4:0]                   o_output_n,
    output logic signed [WEIGHT_WIDTH:0] o_analog_value,
    output logic [1:0]                   o_analog_range,
    output logic                         o_alarm
);

    localparam int NI = scale_io_pkg::INPUT_COUNT;
    localparam int NO = scale_io_pkg::OUTPUT_COUNT;
    localparam int FW = scale_io_pkg::FUNCTION_WIDTH;
    localparam int SW = scale_io_pkg::SOURCE_WIDTH;

    // ------------------------------------------------------------
    // helpers
    // ------------------------------------------------------------
    function automatic logic [WEIGHT_WIDTH-1:0] magnitude(
        input logic signed [WEIGHT_WIDTH-1:0] w
    );
        magnitude = w[WEIGHT_WIDTH-1] ? WEIGHT_WIDTH'(-w) : WEIGHT_WIDTH'(w);
    endfunction : magnitude

    // true when any input assigned to code is flagged in hits
    function automatic logic any_input(
        input logic [NI-1:0]    hits,
        input logic [NI*FW-1:0] sel,
        input scale_io_pkg::input_function_type code
    );
        any_input = 1'b0;
        for (int k = 0; k < NI; k++)
        begin
            if (hits[k] && (sel[k*FW +: FW] == code))
            begin
                any_input = 1'b1;
            end
        end
    endfunction : any_input

    // ------------------------------------------------------------
    // input qualification and decode
    // ------------------------------------------------------------
    logic [NI-1:0] in_level;
    logic [NI-1:0] in_edge;

    for (genvar k = 0; k < NI; k++)
    begin : g_input
        discrete_input_qualifier #(
            .HOLD_CYCLES (HOLD_CYCLES)
        ) u_qualifier (
            .i_clock      (i_clock),
            .i_reset      (i_reset),
            .i_pin_n      (i_input_n[k]),
            .o_level      (in_level[k]),
            .o_edge_pulse (in_edge[k])
        );
    end

    // none matches no branch, so such an input never acts
    wire tare_hit    = any_input(in_edge, i_input_function, scale_io_pkg::IN_TARE);
    wire clear_hit   = any_input(in_edge, i_input_function, scale_io_pkg::IN_CLEAR);
    wire zero_hit    = any_input(in_edge, i_input_function, scale_io_pkg::IN_ZERO);
    wire print_hit   = any_input(in_edge, i_input_function, scale_io_pkg::IN_PRINT);
    wire units_hit   = any_input(in_edge, i_input_function,
                                 scale_io_pkg::IN_SWITCH_UNITS);
    wire dynamic_hit = any_input(in_edge, i_input_function, scale_io_pkg::IN_DYNAMIC);
    wire total_hit   = any_input(in_edge, i_input_function,
                                 scale_io_pkg::IN_ACCUMULATOR_TOTAL);
    wire advance_hit = any_input(in_edge, i_input_function,
                                 scale_io_pkg::IN_ADVANCE_PROMPT);
    wire blank_on    = any_input(in_level, i_input_function,
                                 scale_io_pkg::IN_BLANK_DISPLAY);
    wire inhibit_on  = any_input(in_level, i_input_function,
                                 scale_io_pkg::IN_INHIBIT_KEYPAD);
    wire tenfold_on  = any_input(in_level, i_input_function,
                                 scale_io_pkg::IN_TENFOLD_RESOLUTION);
    wire feed_on     = any_input(in_level, i_input_function,
                                 scale_io_pkg::IN_FEED_PERMIT);
    wire dsch_on     = any_input(in_level, i_input_function,
                                 scale_io_pkg::IN_DISCHARGE_PERMIT);
    wire first_hit   = advance_hit && !i_prompt_mode;
    wire next_hit    = advance_hit && i_prompt_mode;

    // ------------------------------------------------------------
    // weight conditions
    // ------------------------------------------------------------
    wire [WEIGHT_WIDTH-1:0] disp_mag = magnitude(i_displayed_weight);
    wire disp_negative = i_displayed_weight[WEIGHT_WIDTH-1];
    wire over_capacity = !disp_negative && (disp_mag > i_full_scale_capacity);
    wire under_blank   = disp_negative && (disp_mag >= i_zero_blanking_value);
    wire over_blank    = !disp_negative && (disp_mag >= i_over_blanking_value);

    scale_io_pkg::setpoint_weight_type sp_select;
    assign sp_select = scale_io_pkg::setpoint_weight_type'(i_setpoint_weight_select);

    // unused select code falls back to gross weight
    wire signed [WEIGHT_WIDTH-1:0] sp_weight =
        (sp_select == scale_io_pkg::SP_DISPLAYED) ? i_displayed_weight :
        (sp_select == scale_io_pkg::SP_NET)       ? i_net_weight :
                                                     i_gross_weight;
    wire [WEIGHT_WIDTH-1:0] sp_mag = magnitude(sp_weight);
    wire sp_allowed = (sp_select != scale_io_pkg::SP_NET) || i_tare_taken;

    // ------------------------------------------------------------
    // outputs
    // ------------------------------------------------------------
    logic [NO-1:0] out_active;

    for (genvar k = 0; k < NO; k++)
    begin : g_output
        scale_io_pkg::output_source_type src;
        wire [WEIGHT_WIDTH-1:0] sp_value = i_setpoint_value[k*WEIGHT_WIDTH +: WEIGHT_WIDTH];
        wire sp_on = sp_allowed && (sp_mag < sp_value);
        assign src = scale_io_pkg::output_source_type'(i_output_source[k*SW +: SW]);
        assign out_active[k] =
            (src == scale_io_pkg::OUT_SETPOINT)      ? sp_on :
            (src == scale_io_pkg::OUT_NET_MODE)      ? i_net_mode :
            (src == scale_io_pkg::OUT_CENTER_ZERO)   ? i_center_of_zero :
            (src == scale_io_pkg::OUT_MOTION)        ? i_in_motion :
            (src == scale_io_pkg::OUT_OVER_CAPACITY) ? over_capacity :
            (src == scale_io_pkg::OUT_NEGATIVE)      ? disp_negative :
                                                       1'b0;
    end

    // ------------------------------------------------------------
    // analog output behaviour
    // ------------------------------------------------------------
    // the DAC maps the range code to its fixed under/over level per mode
    wire signed [WEIGHT_WIDTH:0] analog_track =
        i_analog_follows_displayed ? $signed({1'b0, disp_mag})
                                   : $signed({i_gross_weight[WEIGHT_WIDTH-1],
                                              i_gross_weight});
    scale_io_pkg::analog_range_type range_next;
    assign range_next = under_blank ? scale_io_pkg::ANALOG_UNDER_RANGE :
                        over_blank  ? scale_io_pkg::ANALOG_OVER_RANGE :
                                      scale_io_pkg::ANALOG_TRACK;
    wire alarm_next = under_blank || over_blank;

    // ------------------------------------------------------------
    // output registers
    // ------------------------------------------------------------
    always_ff @(posedge i_clock or posedge i_reset)
    begin
        if (i_reset)
        begin
            o_tare_pulse                 <= 1'b0;
            o_clear_pulse                <= 1'b0;
            o_zero_pulse                 <= 1'b0;
            o_print_pulse                <= 1'b0;
            o_switch_units_pulse         <= 1'b0;
            o_dynamic_pulse              <= 1'b0;
            o_accumulator_total_pulse    <= 1'b0;
            o_prompt_first_pulse         <= 1'b0;
            o_prompt_next_pulse          <= 1'b0;
            o_blank_display              <= 1'b0;
            o_inhibit_keypad             <= 1'b0;
            o_tenfold_resolution_display <= 1'b0;
            o_feed_permit                <= 1'b0;
            o_discharge_permit           <= 1'b0;
            o_output_n                   <= '1;
            o_analog_value               <= '0;
            o_analog_range               <= scale_io_pkg::ANALOG_TRACK;
            o_alarm                      <= 1'b0;
        end
        else
        begin
            o_tare_pulse                 <= tare_hit;
            o_clear_pulse                <= clear_hit;
            o_zero_pulse                 <= zero_hit;
            o_print_pulse                <= print_hit;
            o_switch_units_pulse         <= units_hit;
            o_dynamic_pulse              <= dynamic_hit;
            o_accumulator_total_pulse    <= total_hit;
            o_prompt_first_pulse         <= first_hit;
            o_prompt_next_pulse          <= next_hit;
            o_blank_display              <= blank_on;
            o_inhibit_keypad             <= inhibit_on;
            o_tenfold_resolution_display <= tenfold_on;
            o_feed_permit                <= feed_on;
            o_discharge_permit           <= dsch_on;
            o_output_n                   <= ~out_active;
            o_analog_value               <= analog_track;
            o_analog_range               <= range_next;
            o_alarm                      <= alarm_next;
        end
    end

endmodule : scale_discrete_io_port

`default_nettype wire

// ---- design/scale_io_pkg.sv ----
package scale_io_pkg;

    // ------------------------------------------------------------
    // sizes
    // ------------------------------------------------------------
    localparam int INPUT_COUNT      = 3;
    localparam int OUTPUT_COUNT     = 5;
    localparam int WEIGHT_WIDTH     = 20;
    localparam int FUNCTION_WIDTH   = 4;
    localparam int SOURCE_WIDTH     = 3;
    localparam int SELECT_WIDTH     = 2;

    // ------------------------------------------------------------
    // timing
    // ------------------------------------------------------------
    localparam int CLOCK_HZ         = 125000000;
    localparam int EDGE_HOLD_MS     = 100;
    localparam int EDGE_HOLD_CYCLES = (CLOCK_HZ / 1000) * EDGE_HOLD_MS;

    // ------------------------------------------------------------
    // reset values
    // ------------------------------------------------------------
    localparam logic PIN_IDLE_LEVEL = 1'b1;

    // ------------------------------------------------------------
    // encodings
    // ------------------------------------------------------------
    typedef enum logic [FUNCTION_WIDTH-1:0] {
        IN_NONE,
        IN_TARE,
        IN_CLEAR,
        IN_ZERO,
        IN_PRINT,
        IN_SWITCH_UNITS,
        IN_BLANK_DISPLAY,
        IN_DYNAMIC,
        IN_INHIBIT_KEYPAD,
        IN_TENFOLD_RESOLUTION,
        IN_ACCUMULATOR_TOTAL,
        IN_FEED_PERMIT,
        IN_DISCHARGE_PERMIT,
        IN_ADVANCE_PROMPT
    } input_function_type;

    typedef enum logic [SOURCE_WIDTH-1:0] {
        OUT_NONE,
        OUT_SETPOINT,
        OUT_NET_MODE,
        OUT_CENTER_ZERO,
        OUT_MOTION,
        OUT_OVER_CAPACITY,
        OUT_NEGATIVE
    } output_source_type;

    typedef enum logic [SELECT_WIDTH-1:0] {
        SP_GROSS,
        SP_DISPLAYED,
        SP_NET
    } setpoint_weight_type;

    typedef enum logic [1:0] {
        ANALOG_TRACK,
        ANALOG_UNDER_RANGE,
        ANALOG_OVER_RANGE
    } analog_range_type;

endpackage : scale_io_pkg

// ---- design/discrete_input_qualifier.sv ----
`timescale 1ns/10ps
`default_nettype none

module discrete_input_qualifier #(
    parameter int HOLD_CYCLES = scale_io_pkg::EDGE_HOLD_CYCLES
) (
    input  wire logic i_clock,
    input  wire logic i_reset,
    input  wire logic i_pin_n,
    output logic      o_level,
    output logic      o_edge_pulse
);

    localparam int CW = $clog2(HOLD_CYCLES + 1);
    localparam logic [CW-1:0] HOLD_LAST = CW'(HOLD_CYCLES - 1);

    logic          sync1_reg;
    logic          sync2_reg;
    logic          sync3_reg;
    logic          level_reg;
    logic          level_next;
    logic          fired_reg;
    logic          fired_next;
    logic          pulse_next;
    logic [CW-1:0] count_reg;
    logic [CW-1:0] count_next;
    logic          agree;
    logic          hold_done;

    // ------------------------------------------------------------
    // qualification
    // ------------------------------------------------------------
    // a floating pin idles high through the pull-up and reads inactive
    assign agree      = (sync2_reg == sync3_reg);
    assign level_next = agree ? ~sync3_reg : level_reg;
    assign hold_done  = level_reg && !fired_reg && (count_reg == HOLD_LAST);
    // one shot per grounding; rearmed only after the pin is released
    assign fired_next = level_reg ? (fired_reg || hold_done) : 1'b0;
    assign pulse_next = hold_done;
    assign count_next = (!level_reg || fired_reg) ? '0 : count_reg + CW'(1);

    always_ff @(posedge i_clock or posedge i_reset)
    begin
        if (i_reset)
        begin
            sync1_reg    <= scale_io_pkg::PIN_IDLE_LEVEL;
            sync2_reg    <= scale_io_pkg::PIN_IDLE_LEVEL;
            sync3_reg    <= scale_io_pkg::PIN_IDLE_LEVEL;
            level_reg    <= 1'b0;
            fired_reg    <= 1'b0;
            count_reg    <= '0;
            o_edge_pulse <= 1'b0;
        end
        else
        begin
            sync1_reg    <= i_pin_n;
            sync2_reg    <= sync1_reg;
            sync3_reg    <= sync2_reg;
            level_reg    <= level_next;
            fired_reg    <= fired_next;
            count_reg    <= count_next;
            o_edge_pulse <= pulse_next;
        end
    end

    assign o_level = level_reg;

endmodule : discrete_input_qualifier

`default_nettype wire

// ---- tb/switch_bank_model.sv ----
`timescale 1ns/10ps
`default_nettype none

module switch_bank_model (
    input  wire logic [2:0] i_ground,
    output logic      [2:0] o_pin_n
);
    // ------------------------------------------------------------
    // contacts
    // ------------------------------------------------------------
    // an open contact never leaves the pin floating: the pull-up wins
    assign o_pin_n = ~i_ground;
endmodule : switch_bank_model

`default_nettype wire

// ---- tb/io_port_chk.sv ----
`timescale 1ns/10ps
`default_nettype none

module io_port_chk #(
    parameter int WEIGHT_WIDTH = 20,
    parameter int HOLD_CYCLES  = 8
) (
    input wire logic                           i_clock,
    input wire logic                           i_reset,
    input wire logic [2:0]                     i_input_n,
    input wire logic                           i_prompt_mode,
    input wire logic                           o_tare_pulse,
    input wire logic                           o_prompt_first_pulse,
    input wire logic                           o_prompt_next_pulse,
    input wire logic                           o_blank_display,
    input wire logic                           o_feed_permit,
    input wire logic [14:0]                    i_output_source,
    input wire logic [5*WEIGHT_WIDTH-1:0]      i_setpoint_value,
    input wire logic [1:0]                     i_setpoint_weight_select,
    input wire logic signed [WEIGHT_WIDTH-1:0] i_gross_weight,
    input wire logic signed [WEIGHT_WIDTH-1:0] i_displayed_weight,
    input wire logic                           i_tare_taken,
    input wire logic [WEIGHT_WIDTH-1:0]        i_over_blanking_value,
    input wire logic [WEIGHT_WIDTH-1:0]        i_zero_blanking_value,
    input wire logic                           i_analog_follows_displayed,
    input wire logic [4:0]                     o_output_n,
    input wire logic signed [WEIGHT_WIDTH:0]   o_analog_value,
    input wire logic [1:0]                     o_analog_range,
    input wire logic                           o_alarm
);
    // ------------------------------------------------------------
    // derived conditions
    // ------------------------------------------------------------
    logic signed [WEIGHT_WIDTH:0] disp_ext;
    logic signed [WEIGHT_WIDTH:0] gross_ext;
    logic        [WEIGHT_WIDTH:0] disp_mag;
    logic        [WEIGHT_WIDTH:0] gross_mag;
    logic                         under_blank;
    logic                         over_blank;
    logic                         sp_hit;
    assign disp_ext    = i_displayed_weight;
    assign gross_ext   = i_gross_weight;
    assign disp_mag    = (disp_ext < 0) ? -disp_ext : disp_ext;
    assign gross_mag   = (gross_ext < 0) ? -gross_ext : gross_ext;
    assign under_blank = (disp_ext < 0) && (disp_mag >= {1'b0, i_zero_blanking_value});
    assign over_blank  = (disp_ext >= 0) && (disp_mag >= {1'b0, i_over_blanking_value});
    assign sp_hit      = gross_mag < {1'b0, i_setpoint_value[WEIGHT_WIDTH-1:0]};

    default clocking @(posedge i_clock); endclocking
    default disable iff (i_reset);

    // six idle samples cover the three synchroniser stages, the level register and the output flop
    sequence pins_idle;
        (i_input_n == 3'h7) [*6];
    endsequence

    // ------------------------------------------------------------
    // assertions
    // ------------------------------------------------------------
    analog_track_a: assert property (
        i_analog_follows_displayed |=> o_analog_value == $signed($past(disp_mag)))
        else $error("analog value does not follow weight magnitude");
    under_blank_a: assert property (
        under_blank |=> o_analog_range == 2'h1 && o_alarm)
        else $error("under blanking not forced");
    over_blank_a: assert property (
        over_blank && !under_blank |=> o_analog_range == 2'h2 && o_alarm)
        else $error("over blanking not forced");
    alarm_cause_a: assert property (
        !under_blank && !over_blank |=> !o_alarm && o_analog_range == 2'h0)
        else $error("alarm without blanking");
    setpoint_gross_a: assert property (
        i_output_source[2:0] == 3'h1 && i_setpoint_weight_select == 2'h0
        |=> o_output_n[0] == !$past(sp_hit))
        else $error("gross setpoint output wrong");
    net_tare_a: assert property (
        i_output_source[2:0] == 3'h1 && i_setpoint_weight_select == 2'h2 && !i_tare_taken
        |=> o_output_n[0])
        else $error("net setpoint on before tare");
    none_out_a: assert property (
        (i_output_source[5:3] == 3'h0 |=> o_output_n[1]) and
        (i_output_source[8:6] == 3'h7 |=> o_output_n[2]))
        else $error("unassigned output driven");
    prompt_choice_a: assert property (
        (o_prompt_first_pulse |-> !$past(i_prompt_mode)) and
        (o_prompt_next_pulse |-> $past(i_prompt_mode)))
        else $error("advance prompt branch wrong");
    level_release_a: assert property (
        pins_idle |=> !o_blank_display && !o_feed_permit)
        else $error("level function outlives its input");
    tare_once_a: assert property (
        o_tare_pulse |=> !o_tare_pulse [*8])
        else $error("edge function fired again");
endmodule : io_port_chk

bind scale_discrete_io_port io_port_chk #(
    .WEIGHT_WIDTH(WEIGHT_WIDTH),
    .HOLD_CYCLES (HOLD_CYCLES)
) chk (
    .i_clock, .i_reset, .i_input_n, .i_prompt_mode, .o_tare_pulse, .o_prompt_first_pulse,
    .o_prompt_next_pulse, .o_blank_display, .o_feed_permit, .i_output_source,
    .i_setpoint_value, .i_setpoint_weight_select, .i_gross_weight, .i_displayed_weight,
    .i_tare_taken, .i_over_blanking_value, .i_zero_blanking_value,
    .i_analog_follows_displayed, .o_output_n, .o_analog_value, .o_analog_range, .o_alarm
);

`default_nettype wire

// ---- tb/tb.sv ----
`timescale 1ns/10ps
`default_nettype none

module tb;
    logic                   i_clock;
    logic                   i_reset;
    logic        [2:0]      ground = 3'h0;
    wire  logic  [2:0]      pin_n;
    logic        [11:0]     fn;
    logic                   pmode;
    logic        [14:0]     src;
    logic        [1:0]      sel;
    logic signed [19:0]     gross, net, disp;
    logic                   tare, netm, cz, motion, follow;
    logic        [8:0]      pulse, seen;
    logic        [4:0]      lvl, out_n;
    logic signed [20:0]     aval;
    logic        [1:0]      rng;
    logic                   alarm;
    int                     n_fail = 0, samples_checked = 0, cycles = 0, hits;
    int                     edge_code[8] = '{1, 2, 3, 4, 5, 7, 10, 13};
    int                     level_code[5] = '{6, 8, 9, 11, 12};

    switch_bank_model sw (.i_ground(ground), .o_pin_n(pin_n));

    // a short hold stands in for the 100 ms qualification time
    scale_discrete_io_port #(.HOLD_CYCLES(8)) dut (
        .i_clock(i_clock), .i_reset(i_reset), .i_input_n(pin_n), .i_input_function(fn),
        .i_prompt_mode(pmode), .o_tare_pulse(pulse[0]), .o_clear_pulse(pulse[1]),
        .o_zero_pulse(pulse[2]), .o_print_pulse(pulse[3]), .o_switch_units_pulse(pulse[4]),
        .o_dynamic_pulse(pulse[5]), .o_accumulator_total_pulse(pulse[6]),
        .o_prompt_first_pulse(pulse[7]), .o_prompt_next_pulse(pulse[8]),
        .o_blank_display(lvl[0]), .o_inhibit_keypad(lvl[1]),
        .o_tenfold_resolution_display(lvl[2]), .o_feed_permit(lvl[3]),
        .o_discharge_permit(lvl[4]), .i_output_source(src), .i_setpoint_value({5{20'h00064}}),
        .i_setpoint_weight_select(sel), .i_gross_weight(gross), .i_net_weight(net),
        .i_displayed_weight(disp), .i_tare_taken(tare), .i_net_mode(netm),
        .i_center_of_zero(cz), .i_in_motion(motion), .i_full_scale_capacity(20'h003E8),
        .i_over_blanking_value(20'h007D0), .i_zero_blanking_value(20'h00200),
        .i_analog_follows_displayed(follow), .o_output_n(out_n), .o_analog_value(aval),
        .o_analog_range(rng), .o_alarm(alarm));

    initial
    begin
        i_clock = 1'b0;
        forever #4 i_clock = ~i_clock;
    end

    task automatic tick();
        @(posedge i_clock);
        #1;
    endtask : tick

    task automatic check(input string name, input logic [31:0] got, input logic [31:0] exp);
        samples_checked++;
        if (got !== exp)
        begin
            n_fail++;
            $display("wrong value %s expected %0h seen %0h", name, exp, got);
        end
    endtask : check

    task automatic press(input int k, input int code, input int hold);
        fn = 12'h000;
        fn[4*k +: 4] = code;
        seen = 9'h000;
        hits = 0;
        for (int c = 0; c < hold + 30; c++)
        begin
            ground[k] = (c < hold);
            tick();
            seen |= pulse;
            hits += $countones(pulse);
        end
    endtask : press

    task automatic io(input logic [1:0] s, input int g, input int n, input int d,
                      input logic [4:0] en, input int ev, input logic [1:0] er, input logic ea);
        sel = s;
        gross = g;
        net = n;
        disp = d;
        tick();
        check("output pins", out_n, en);
        check("analog value", aval, ev);
        check("analog range", rng, er);
        check("alarm", alarm, ea);
    endtask : io

    task automatic summarize();
        if (n_fail == 0 && samples_checked > 0)
            $display("RESULT: PASS");
        else
            $display("RESULT: FAIL");
        $finish;
    endtask : summarize

    always @(posedge i_clock)
    begin
        cycles++;
        if (cycles == 5000)
        begin
            n_fail++;
            summarize();
        end
    end

    initial
    begin
        {i_reset, fn, pmode, src, sel} = {1'b1, 12'h000, 1'b0, 15'h58D1, 2'h0};
        {gross, net, disp, tare, netm, cz, motion, follow} = {60'h0, 5'h0B};
        repeat (5) @(posedge i_clock);
        #1 i_reset = 1'b0;
        tick();
        // ------------------------------------------------------------
        // edge functions, spread over all three inputs
        // ------------------------------------------------------------
        for (int i = 0; i < 8; i++)
        begin
            press(i % 3, edge_code[i], 16);
            check("edge pulse", seen, 9'h001 << i);
            check("edge count", hits, 1);
        end
        pmode = 1'b1;
        press(1, 13, 16);
        check("next prompt", seen, 9'h100);
        press(2, 1, 4);
        check("short press", hits, 0);
        press(0, 1, 60);
        check("held press", hits, 1);
        press(1, 0, 16);
        check("none input", hits, 0);
        press(2, 14, 16);
        check("spare code", hits, 0);
        for (int i = 0; i < 5; i++)
        begin
            fn = 12'h000;
            fn[4*(i%3) +: 4] = level_code[i];
            ground[i%3] = 1'b1;
            repeat (8) tick();
            check("level on", lvl, 5'h01 << i);
            ground[i%3] = 1'b0;
            repeat (8) tick();
            check("level off", lvl, 5'h00);
        end
        // ------------------------------------------------------------
        // outputs and analog
        // ------------------------------------------------------------
        io(0, -50, 0, 0, 5'h14, 0, 0, 0);
        io(3, -50, 0, 0, 5'h14, 0, 0, 0);
        io(0, 100, 0, 0, 5'h15, 0, 0, 0);
        io(0, -150, 0, 0, 5'h15, 0, 0, 0);
        io(2, 0, 10, 0, 5'h15, 0, 0, 0);
        tare = 1'b1;
        io(2, 0, 10, 0, 5'h14, 0, 0, 0);
        io(1, 500, 0, -99, 5'h14, 99, 0, 0);
        io(0, 0, 0, -511, 5'h14, 511, 0, 0);
        io(0, 0, 0, -512, 5'h14, 512, 1, 1);
        io(0, 0, 0, 1500, 5'h04, 1500, 0, 0);
        io(0, 0, 0, 2000, 5'h04, 2000, 2, 1);
        follow = 1'b0;
        io(0, -50, 0, 0, 5'h14, -50, 0, 0);
        {netm, cz, motion, follow} = 4'h5;
        io(1, 0, 0, 1001, 5'h0B, 1001, 0, 0);
        src = 15'h59C6;
        io(0, 0, 0, -5, 5'h1E, 5, 0, 0);
        io(0, 0, 0, 5, 5'h1F, 5, 0, 0);
        summarize();
    end
endmodule : tb

`default_nettype wire
